// File: src/light_alert_defines.vh
// Constants for the light threshold alert block: register map, field
// positions, reset values and pulse timing.
// Assumes a 25 MHz hclk and a 32-bit AHB-Lite register bus.
`ifndef LIGHT_ALERT_DEFINES_VH
`define LIGHT_ALERT_DEFINES_VH

// Register byte offsets
`define REG_CONFIG 4'h0
`define REG_HIGH_LIMIT 4'h4
`define REG_LOW_LIMIT 4'h8
`define REG_FLAGS 4'hC

// Configuration fields
`define CFG_COMPARE_MODE 0
`define CFG_PIN_FUNC_LO 1
`define CFG_PIN_FUNC_HI 2
`define CFG_POLARITY 3
`define CFG_FAULT_CNT_LO 4
`define CFG_FAULT_CNT_HI 5
`define CFG_WIDTH 6

// Limit fields: 12-bit result below a 4-bit exponent
`define LIM_RESULT_HI 11
`define LIM_EXP_LO 12
`define LIM_EXP_HI 15
`define LIM_WIDTH 16

// Flag register fields
`define FLG_HIGH 0
`define FLG_LOW 1
`define FLG_ALERT 2

// Reset values
`define CONFIG_RESET 6'h00
`define HIGH_LIMIT_RESET 16'hFFFF
`define LOW_LIMIT_RESET 16'h0000

// Compare modes and pin functions
`define MODE_HYSTERESIS 1'b0
`define MODE_LATCHED 1'b1
`define PIN_THRESHOLD 2'h0
`define PIN_EVERY_CONV 2'h1
`define PIN_FIFO_FULL 2'h3

// Limit zero padding and linear compare width
`define LIMIT_PAD 8
`define LINEAR_WIDTH 36

// Pulse timing
`define CLK_PERIOD_NS 40
`define PULSE_WIDTH_NS 1000
// 1000 ns at 40 ns per clock; sized to fit the 5-bit pulse timer
`define PULSE_CYCLES 5'h19
`define FIFO_DEPTH_CONV 2'h3

`endif

// File: src/linear_expand.v
// Expands a mantissa and a binary exponent to one linear code by shifting
// in zeros. Purely combinational; the caller compares the result without registering it.
`timescale 1ns/1ps

module linear_expand #(
  parameter W_IN = 12,
  parameter PAD = 8
)
(
  // Semi-logarithmic value
  input wire [W_IN-1:0] mantissa,
  input wire [3:0] exponent,
  // Linear value
  output wire [35:0] linear
);

  wire [35:0] wide;
  wire [4:0] shift;

  // Zero padding: mantissa moved up by PAD plus the exponent
  assign wide = {{(36-W_IN){1'b0}}, mantissa};
  assign shift = exponent + PAD[4:0];
  assign linear = wide << shift;

endmodule // linear_expand

// File: src/fault_persist.v
// Counts an uninterrupted run of fault events and reports when the run
// has reached the required length. Same clock as the caller.
`timescale 1ns/1ps

module fault_persist
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Event input
  input wire sample,
  input wire fault,
  input wire [3:0] need,
  // Qualified fault, valid while sample is high
  output wire hit
);

  reg [3:0] run_q;
  wire [3:0] run_d;

  // This event completes the run when earlier ones numbered need-1
  assign hit = fault && (run_q >= (need - 4'h1));

  // Saturate at the target so a long fault keeps qualifying
  assign run_d = !fault ? 4'h0 : (hit ? run_q : run_q + 4'h1);

  // Only completed conversions move the count
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_q <= 4'h0;
    else if (sample)
      run_q <= run_d;
  end

endmodule // fault_persist

// File: src/light_alert.v
// Threshold comparison, persistence and alert pin logic of a light sensor,
// with its registers on an AHB-Lite slave.
// Assumes conversion results arrive on hclk with a one-cycle done pulse and
// that an external pull-up sits on the alert line.
`timescale 1ns/1ps
`include "light_alert_defines.vh"

module light_alert
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Conversion results
  input wire conv_done,
  input wire [19:0] meas_mantissa,
  input wire [3:0] meas_exponent,
  // Open-drain alert pin
  output reg alert_out,
  output reg alert_oe_n
);

  localparam [4:0] PULSE_LEN = `PULSE_CYCLES;

  // Register storage
  reg [`CFG_WIDTH-1:0] config_q;
  reg [`LIM_WIDTH-1:0] high_limit_q;
  reg [`LIM_WIDTH-1:0] low_limit_q;
  reg flag_high_q;
  reg flag_low_q;
  reg alert_state_q;

  // Bus data-phase state
  reg wr_pend_q;
  reg [3:0] wr_addr_q;

  // Pulse generation state
  reg [4:0] pulse_cnt_q;
  reg [1:0] conv_cnt_q;

  // Configuration fields
  wire compare_mode;
  wire [1:0] pin_function;
  wire alert_polarity;
  wire [1:0] fault_count;
  wire [3:0] need;

  // Bus decode
  wire addr_phase;
  wire [3:0] addr_lo;
  wire word_hit;
  wire rd_take;
  wire flags_read;

  // Comparison
  wire [35:0] meas_lin;
  wire [35:0] high_lin;
  wire [35:0] low_lin;
  wire fault_high;
  wire fault_low;
  wire hit_high;
  wire hit_low;

  // Next states
  reg flag_high_d;
  reg flag_low_d;
  reg alert_state_d;
  reg [31:0] rdata_d;
  wire pulse_start;
  wire alert_active;
  wire pin_level;

  assign compare_mode = config_q[`CFG_COMPARE_MODE];
  assign pin_function = config_q[`CFG_PIN_FUNC_HI:`CFG_PIN_FUNC_LO];
  assign alert_polarity = config_q[`CFG_POLARITY];
  assign fault_count = config_q[`CFG_FAULT_CNT_HI:`CFG_FAULT_CNT_LO];

  // Run length 1, 2, 4 or 8 conversions
  assign need = 4'h1 << fault_count;

  // Only word-aligned accesses in the low 16 bytes are mapped; hsize is not decoded
  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_lo = haddr[3:0];
  assign word_hit = (haddr[31:4] == 28'h0) && (addr_lo[1:0] == 2'h0);
  assign rd_take = addr_phase && !hwrite;
  assign flags_read = rd_take && word_hit && (addr_lo == `REG_FLAGS);

  // Linear measurement, and limits padded with zeros
  linear_expand #(
    .W_IN(20),
    .PAD(0)
  ) meas_expand (
    .mantissa(meas_mantissa),
    .exponent(meas_exponent),
    .linear(meas_lin)
  );

  linear_expand #(
    .W_IN(12),
    .PAD(`LIMIT_PAD)
  ) high_expand (
    .mantissa(high_limit_q[`LIM_RESULT_HI:0]),
    .exponent(high_limit_q[`LIM_EXP_HI:`LIM_EXP_LO]),
    .linear(high_lin)
  );

  linear_expand #(
    .W_IN(12),
    .PAD(`LIMIT_PAD)
  ) low_expand (
    .mantissa(low_limit_q[`LIM_RESULT_HI:0]),
    .exponent(low_limit_q[`LIM_EXP_HI:`LIM_EXP_LO]),
    .linear(low_lin)
  );

  // Fault events from the raw comparison
  assign fault_high = meas_lin > high_lin;
  assign fault_low = meas_lin < low_lin;

  // Separate runs per direction, so alternating faults qualify only when need is 1
  fault_persist high_run (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(conv_done),
    .fault(fault_high),
    .need(need),
    .hit(hit_high)
  );

  fault_persist low_run (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(conv_done),
    .fault(fault_low),
    .need(need),
    .hit(hit_low)
  );

  // Flag and threshold pin state; a qualified event beats a same-cycle
  // read clear, so no event is lost
  always @*
  begin
    flag_high_d = flag_high_q;
    flag_low_d = flag_low_q;
    alert_state_d = alert_state_q;
    if (compare_mode == `MODE_LATCHED)
    begin
      if (flags_read)
      begin
        flag_high_d = 1'b0;
        flag_low_d = 1'b0;
        alert_state_d = 1'b0;
      end
      if (conv_done && hit_high)
      begin
        flag_high_d = 1'b1;
        alert_state_d = 1'b1;
      end
      if (conv_done && hit_low)
      begin
        flag_low_d = 1'b1;
        alert_state_d = 1'b1;
      end
    end
    else if (conv_done)
    begin
      // Between the limits nothing changes
      if (hit_high)
      begin
        flag_high_d = 1'b1;
        flag_low_d = 1'b0;
        alert_state_d = 1'b1;
      end
      else if (hit_low)
      begin
        flag_high_d = 1'b0;
        flag_low_d = 1'b1;
        alert_state_d = 1'b0;
      end
    end
  end

  // Mode selects latching; hysteresis state changes only on a qualified limit crossing
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_high_q <= 1'b0;
      flag_low_q <= 1'b0;
      alert_state_q <= 1'b0;
    end
    else
    begin
      flag_high_q <= flag_high_d;
      flag_low_q <= flag_low_d;
      alert_state_q <= alert_state_d;
    end
  end

  // Pulse request: every conversion, or every fourth one
  assign pulse_start = conv_done &&
    ((pin_function == `PIN_EVERY_CONV) ||
     ((pin_function == `PIN_FIFO_FULL) &&
      (conv_cnt_q == `FIFO_DEPTH_CONV)));

  // Conversion count wraps with the four-deep FIFO
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conv_cnt_q <= 2'h0;
    else if (conv_done)
      conv_cnt_q <= conv_cnt_q + 2'h1;
  end

  // Pulse timer; a new request restarts the full width
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pulse_cnt_q <= 5'h00;
    else if (pulse_start)
      pulse_cnt_q <= PULSE_LEN;
    else if (pulse_cnt_q != 5'h00)
      pulse_cnt_q <= pulse_cnt_q - 5'h01;
  end

  // Threshold state drives the pin only in function 0
  assign alert_active = (pin_function == `PIN_THRESHOLD) ?
    alert_state_q : (pulse_cnt_q != 5'h00);

  // Active-high polarity drives the active level high, else low
  assign pin_level = alert_polarity ? alert_active : !alert_active;

  // Open drain: pull low for level 0, release for level 1
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
    end
    else
    begin
      alert_out <= 1'b0;
      alert_oe_n <= pin_level;
    end
  end

  // Read mux, sampled in the address phase for a zero-wait data phase
  always @*
  begin
    rdata_d = 32'h00000000;
    if (word_hit)
    begin
      case (addr_lo)
        `REG_CONFIG: rdata_d[`CFG_WIDTH-1:0] = config_q;
        `REG_HIGH_LIMIT: rdata_d[`LIM_WIDTH-1:0] = high_limit_q;
        `REG_LOW_LIMIT: rdata_d[`LIM_WIDTH-1:0] = low_limit_q;
        `REG_FLAGS:
        begin
          rdata_d[`FLG_HIGH] = flag_high_q;
          rdata_d[`FLG_LOW] = flag_low_q;
          rdata_d[`FLG_ALERT] = alert_active;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Bus response: always ready and OKAY
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_take)
        hrdata <= rdata_d;
    end
  end

  // Write address held over to the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
    end
    else if (hready)
    begin
      wr_pend_q <= addr_phase && hwrite && word_hit;
      wr_addr_q <= addr_lo;
    end
  end

  // Writable registers; the flag register is read only
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      config_q <= `CONFIG_RESET;
      high_limit_q <= `HIGH_LIMIT_RESET;
      low_limit_q <= `LOW_LIMIT_RESET;
    end
    else if (wr_pend_q)
    begin
      case (wr_addr_q)
        `REG_CONFIG: config_q <= hwdata[`CFG_WIDTH-1:0];
        `REG_HIGH_LIMIT: high_limit_q <= hwdata[`LIM_WIDTH-1:0];
        `REG_LOW_LIMIT: low_limit_q <= hwdata[`LIM_WIDTH-1:0];
        default: config_q <= config_q;
      endcase
    end
  end

endmodule // light_alert

// File: tb/light_alert_properties.sv
// Assertions on the alert pin and bus side of light_alert.
// Assumes hready is tied to hreadyout; config is shadowed from bus writes.
`timescale 1ns/1ps

module light_alert_properties
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Conversions and pin
  input wire conv_done,
  input wire alert_out,
  input wire alert_oe_n
);
  reg wc_q;
  reg p_q;
  reg [5:0] cfg_q;
  reg [1:0] n_q;
  wire [1:0] fn = cfg_q[2:1];
  wire rd_c = hsel && htrans[1] && hready && !hwrite && haddr == 32'hC;
  wire act = alert_oe_n == p_q;

  // Config shadow; polarity lags one edge, as the pin does
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wc_q <= 1'b0;
      p_q <= 1'b0;
      cfg_q <= 6'h00;
      n_q <= 2'h0;
    end
    else
    begin
      wc_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
      p_q <= cfg_q[3];
      if (wc_q)
        cfg_q <= hwdata[5:0];
      if (conv_done)
        n_q <= n_q + 2'h1;
    end

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Two quiet cycles, so a change cannot come from a late cause
  sequence s_quiet;
    !conv_done && $stable(cfg_q);
  endsequence
  sequence s_held;
    act && !rd_c && $stable(cfg_q);
  endsequence

  a_open_drain: assert property (alert_out == 1'b0)
    else $error("alert pin driven high");
  a_bus_ready: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_read_zero: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr == 32'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_pulse_start: assert property (conv_done && fn == 2'h1 |-> ##2 act)
    else $error("no pulse after conversion");
  a_pulse_end: assert property (fn == 2'h1 && $past(cfg_q, 2) == cfg_q
    && $fell(act) |-> $past(conv_done, 27))
    else $error("pulse width wrong");
  a_fifo_pulse: assert property (conv_done && fn == 2'h3 && n_q == 2'h3
    |-> ##2 act)
    else $error("no pulse on fourth conversion");
  a_latch_hold: assert property (cfg_q[0] && fn == 2'h0 ##0 s_held [*2]
    |=> act)
    else $error("latched alert dropped without read");
  a_hys_quiet: assert property (!cfg_q[0] && fn == 2'h0 ##0 s_quiet [*2]
    |=> $stable(alert_oe_n))
    else $error("pin moved without conversion");
endmodule // light_alert_properties

// File: tb/alert_line.sv
// Host view of the open-drain alert line with its pull-up.
// Assumes the device only pulls low or lets go.
`timescale 1ns/1ps

module alert_line
(
  // Device side
  input wire alert_out,
  input wire alert_oe_n,
  // Host side
  output wire line
);
  // A released line floats up to the pull-up level
  assign line = alert_oe_n ? 1'b1 : alert_out;
endmodule // alert_line

// File: tb/tb_top.sv
// Self-checking bench for light_alert: registers, thresholds, pulses.
// Assumes one AHB-Lite master and a pulled-up alert line.
`timescale 1ns/1ps

module tb_top;
  reg hclk, hresetn, hsel, hwrite, conv_done, pol;
  reg [31:0] haddr, hwdata, rdat;
  reg [1:0] htrans;
  reg [19:0] mant;
  reg [3:0] expo;
  wire hreadyout, hresp, alert_out, alert_oe_n, line;
  wire [31:0] hrdata;
  integer n_fail = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer n_cv = 0;
  integer i;
  wire act = line == pol;

  light_alert i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conv_done(conv_done),
    .meas_mantissa(mant), .meas_exponent(expo),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  alert_line i_line (.alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .line(line));

  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Cut a hang short; whole run needs well under this
  always @(posedge hclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      summarize;
    end
  end

  task summarize;
  begin
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // Single word transfer; read data taken at the data-phase edge
  task bus(input w, input [31:0] a, input [31:0] d);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rdat = hrdata;
  end
  endtask

  task rchk(input [31:0] a, input [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  end
  endtask

  // One conversion; returns once the pin has had its edge to react
  task conv(input [19:0] m, input [3:0] e);
  begin
    @(posedge hclk);
    mant <= m;
    expo <= e;
    conv_done <= 1'b1;
    @(posedge hclk);
    conv_done <= 1'b0;
    n_cv = n_cv + 1;
    @(posedge hclk);
    #1;
  end
  endtask

  task cv(input [19:0] m, input [3:0] e, input a);
  begin
    conv(m, e);
    chk(act, a);
  end
  endtask

  // Pulse must last exactly 25 cycles
  task pls(input a);
  begin
    cv(20'h258, 4'h0, a);
    repeat (24) @(posedge hclk);
    #1;
    chk(act, a);
    @(posedge hclk);
    #1;
    chk(act, 1'b0);
  end
  endtask

  task t_reg;
  begin
    rchk(32'h0, 32'h0);
    rchk(32'h4, 32'hFFFF);
    rchk(32'h8, 32'h0);
    bus(1'b1, 32'h10, 32'h5);
    rchk(32'h10, 32'h0);
    bus(1'b1, 32'h4, 32'h1001);
    bus(1'b1, 32'h8, 32'h0001);
    rchk(32'h4, 32'h1001);
    rchk(32'hC, 32'h0);
  end
  endtask

  // Limits 512 and 256; equal values are not faults
  task t_hys;
  begin
    pol = 1'b1;
    bus(1'b1, 32'h0, 32'h8);
    cv(20'h258, 4'h0, 1'b1);
    rchk(32'hC, 32'h5);
    cv(20'h12C, 4'h0, 1'b1);
    cv(20'h200, 4'h0, 1'b1);
    rchk(32'hC, 32'h5);
    cv(20'h64, 4'h0, 1'b0);
    rchk(32'hC, 32'h2);
    cv(20'h100, 4'h0, 1'b0);
    cv(20'h4B, 4'h3, 1'b1);
    bus(1'b1, 32'h0, 32'h28);
    for (i = 0; i < 7; i = i + 1)
      cv(i == 3 ? 20'h12C : 20'h64, 4'h0, 1'b1);
    cv(20'h64, 4'h0, 1'b0);
  end
  endtask

  task t_latch;
  begin
    pol = 1'b0;
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b0, 32'hC, 32'h0);
    cv(20'h12C, 4'h0, 1'b0);
    cv(20'h258, 4'h0, 1'b1);
    cv(20'h12C, 4'h0, 1'b1);
    cv(20'h64, 4'h0, 1'b1);
    rchk(32'hC, 32'h7);
    #1;
    chk(act, 1'b0);
    rchk(32'hC, 32'h0);
  end
  endtask

  task t_pulse;
  begin
    pol = 1'b1;
    bus(1'b1, 32'h0, 32'hA);
    pls(1'b1);
    rchk(32'hC, 32'h1);
    pol = 1'b0;
    bus(1'b1, 32'h0, 32'h2);
    pls(1'b1);
    pol = 1'b1;
    bus(1'b1, 32'h0, 32'hE);
    for (i = 0; i < 4; i = i + 1)
      pls(n_cv % 4 == 3);
    bus(1'b1, 32'h0, 32'hC);
    cv(20'h258, 4'h0, 1'b0);
  end
  endtask

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    conv_done = 1'b0;
    mant = 20'h0;
    expo = 4'h0;
    pol = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reg;
    t_hys;
    t_latch;
    t_pulse;
    summarize;
  end
endmodule // tb_top

bind light_alert light_alert_properties i_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .conv_done(conv_done), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
